// file: verilog/wts_pkg.sv
// Purpose: Shared constants of the wireless transmitter fault supervisor.
// Assumes: 250 MHz system clock; the _MS durations are counted in millisecond ticks, tone and power-on in clock cycles.
// Notes: Register offsets are byte addresses on a 32-bit AXI4-Lite bus.
package wts_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_KHZ = 250000;
  localparam int TONE_HZ = 4000;
  // One millisecond tick and one tone half period, in clock cycles.
  localparam int MS_CYCLES = CLK_KHZ;
  localparam int TONE_HALF_CYCLES = (CLK_KHZ * 1000) / (2 * TONE_HZ);
  localparam int POR_CYCLES = 1024;

  localparam logic [18:0] SENSOR_LOW_MS = 19'h00096;
  localparam logic [18:0] START_SIG_MS = 19'h00190;
  localparam logic [18:0] PING_ACTIVE_MS = 19'h000D2;
  localparam logic [18:0] PING_PERIOD_MS = 19'h00190;
  localparam logic [18:0] DETECT_LIMIT_MS = 19'h001F4;
  localparam logic [18:0] RETRY_5S_MS = 19'h01388;
  localparam logic [18:0] RETRY_1MIN_MS = 19'h0EA60;
  localparam logic [18:0] RETRY_5MIN_MS = 19'h493E0;
  localparam logic [18:0] WARN_HOLD_MS = 19'h02EE0;
  localparam logic [18:0] WARN_BUZZ_MS = 19'h007D0;

  // ----------------------------------------------------------------
  // Thresholds and charge levels
  // ----------------------------------------------------------------
  localparam logic [15:0] THR_BASE_MW = 16'h00FA;
  localparam logic [15:0] THR_STEP_MW = 16'h0032;
  localparam logic [3:0] BIN_DISABLED = 4'hD;
  localparam logic [3:0] BIN_RESET = 4'h3;
  localparam logic [6:0] CHARGE_FULL_PCT = 7'h64;
  localparam logic [6:0] CHARGE_RESUME_PCT = 7'h5A;

  // ----------------------------------------------------------------
  // End-of-transfer codes and indicator states
  // ----------------------------------------------------------------
  localparam logic [3:0] EPT_DONE = 4'h1;
  localparam logic [3:0] EPT_TEMP = 4'h3;
  localparam logic [3:0] EPT_RECONF = 4'h7;
  localparam logic [2:0] IND_STANDBY = 3'h0;
  localparam logic [2:0] IND_XFER = 3'h1;
  localparam logic [2:0] IND_FULL = 3'h2;
  localparam logic [2:0] IND_FAULT = 3'h3;
  localparam logic [2:0] IND_WARN = 3'h4;

  // ----------------------------------------------------------------
  // Register map and fields
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_RETRY = 8'h08;
  localparam logic [7:0] REG_LOSS = 8'h0C;
  localparam logic [7:0] REG_EVENTS = 8'h10;
  localparam int CTRL_FO_LSB = 0;
  localparam int CTRL_LEG_LSB = 4;
  localparam int CTRL_SCHEME_LSB = 8;
  localparam logic [3:0] SCHEME_RESET = 4'h1;
  localparam int EV_LOSS = 0;
  localparam int EV_SENSOR = 1;
  localparam int EV_OC = 2;
  localparam int EV_WARN = 3;
  localparam int EV_EPT = 4;
  localparam int EV_FULL = 5;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {ST_PING, ST_XFER, ST_HOLD} wts_state_t;

endpackage : wts_pkg

// file: verilog/wts_supervisor.sv
// Purpose: Fault supervision, retry timing, start signals and standby pinging.
// Assumes: Packet decoding and loss estimation arrive as same-clock pulses.
// Notes: The sensor comparator input is asynchronous and is synchronised here.
//
// How it works
// RULE_01: Loss above the selected threshold flags a fault and halts transfer.
// RULE_02: Receiver identification picks the newer or the legacy loss check.
// RULE_03: Bin 0 to 12 sets threshold 250 mW plus 50 mW per bin.
// RULE_04: Bin 13 disables that loss check; it never raises a fault.
// RULE_05: Sensor below threshold for more than 150 ms shuts transfer down.
// RULE_06: A sensor shutdown is shown as a fault on the indicator.
// RULE_07: After sensor shutdown resume after five minutes or on receiver removal.
// RULE_08: End-of-transfer code selects immediate, 5 s, 5 min or no retry.
// RULE_09: Over-current waits one minute; sensor and loss faults five minutes.
// RULE_10: Loss warning holds 12 s; buzzer joins in the last 2 s.
// RULE_11: Receiver removal cuts any pending retry wait short.
// RULE_12: Transfer start drives a 4 kHz square tone for 400 ms.
// RULE_13: Transfer start drives the start pulse high for 400 ms.
// RULE_14: The device stays in reset while the external reset is low.
// RULE_15: An internal power-on sequence holds logic idle until startup completes.
// RULE_16: Standby pings at a fixed interval, each ping active 210 ms.
// RULE_17: Ping interval must let a new receiver be found within 0.5 s.
// RULE_18: Charge-complete code switches the indicator to charge complete.
// RULE_19: Charge status of 100% shows complete but keeps power flowing.
// RULE_20: A later charge status below 90% restores the charging indicator.
// RULE_21: One retry timer holds transfer off until expiry or removal.
`timescale 1ns/100ps

module wts_supervisor
  import wts_pkg::*;
#(
  parameter int CYC_PER_MS = MS_CYCLES,
  parameter int CYC_PER_TONE_HALF = TONE_HALF_CYCLES,
  parameter int POR_LEN = POR_CYCLES
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic sensor_above,
  input wire logic rx_detected,
  input wire logic rx_removed,
  input wire logic id_valid,
  input wire logic id_legacy,
  input wire logic loss_valid,
  input wire logic [15:0] loss_mw,
  input wire logic loss_warning,
  input wire logic over_current,
  input wire logic ept_valid,
  input wire logic [3:0] ept_code,
  input wire logic cs_valid,
  input wire logic [6:0] cs_pct,
  output logic power_enable_q,
  output logic ping_active_q,
  output logic tone_q,
  output logic start_pulse_q,
  output logic warn_buzz_q,
  output logic [2:0] indicator_q,
  output logic [3:0] indicator_scheme_select_q
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (CYC_PER_MS < 2 || CYC_PER_TONE_HALF < 1 || POR_LEN < 1)
    $error("wts_supervisor: timing parameters out of range");
  if (PING_PERIOD_MS > DETECT_LIMIT_MS || PING_PERIOD_MS <= PING_ACTIVE_MS) // RULE_17
    $error("wts_supervisor: ping period must lie between ping length and 500 ms");

  function automatic logic [15:0] bin_to_mw(input logic [3:0] bin);
    bin_to_mw = THR_BASE_MW + 16'(THR_STEP_MW * 16'(bin)); // RULE_03
  endfunction : bin_to_mw

  // ----------------------------------------------------------------
  // Reset sequencing and millisecond tick
  // ----------------------------------------------------------------
  logic [31:0] por_cnt_q;
  logic por_done_q;
  logic run;
  logic [31:0] pre_q;
  logic tick_q;

  // Logic stays held while the pin is low and until the startup count runs out.
  always_ff @(posedge aclk)
  begin
    if (!aresetn) // RULE_14
    begin
      por_cnt_q <= '0;
      por_done_q <= 1'b0;
    end
    else if (!por_done_q) // RULE_15
    begin
      por_cnt_q <= por_cnt_q + 32'h1;
      por_done_q <= (por_cnt_q == 32'(POR_LEN - 1));
    end
  end

  assign run = aresetn && por_done_q;

  always_ff @(posedge aclk)
  begin
    if (!run)
    begin
      pre_q <= '0;
      tick_q <= 1'b0;
    end
    else
    begin
      tick_q <= (pre_q == 32'(CYC_PER_MS - 1));
      pre_q <= (pre_q == 32'(CYC_PER_MS - 1)) ? 32'h0 : pre_q + 32'h1;
    end
  end

  // ----------------------------------------------------------------
  // Sensor synchroniser and low-time filter
  // ----------------------------------------------------------------
  logic sens_m_q;
  logic sens_s_q;
  logic [18:0] low_ms_q;
  logic sens_trip;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sens_m_q <= 1'b1;
      sens_s_q <= 1'b1;
    end
    else
    begin
      sens_m_q <= sensor_above;
      sens_s_q <= sens_m_q;
    end
  end

  // A single bright clock cycle restarts the count, so only a continuous low trips.
  always_ff @(posedge aclk)
  begin
    if (!run || sens_s_q)
      low_ms_q <= '0;
    else if (tick_q && low_ms_q <= SENSOR_LOW_MS)
      low_ms_q <= low_ms_q + 19'h1;
  end

  assign sens_trip = tick_q && !sens_s_q && (low_ms_q == SENSOR_LOW_MS); // RULE_05

  // ----------------------------------------------------------------
  // Loss check selection
  // ----------------------------------------------------------------
  logic [31:0] ctrl_q;
  logic use_legacy_q;
  logic [3:0] sel_bin;
  logic loss_trip;

  always_ff @(posedge aclk)
  begin
    if (!run)
      use_legacy_q <= 1'b0;
    else if (id_valid)
      use_legacy_q <= id_legacy; // RULE_02
  end

  assign sel_bin = use_legacy_q ? ctrl_q[CTRL_LEG_LSB +: 4] : ctrl_q[CTRL_FO_LSB +: 4];
  assign loss_trip = loss_valid && (sel_bin < BIN_DISABLED) // RULE_04
    && (loss_mw > bin_to_mw(sel_bin)); // RULE_01

  // ----------------------------------------------------------------
  // Transfer state and single retry timer
  // ----------------------------------------------------------------
  wts_state_t st_q;
  logic [18:0] hold_ms_q;
  logic [18:0] ping_ms_q;
  logic warn_q;
  logic fault_q;
  logic begin_xfer;

  assign begin_xfer = (st_q == ST_PING) && ping_active_q && rx_detected;

  always_ff @(posedge aclk)
  begin
    if (!run)
    begin
      st_q <= ST_PING;
      hold_ms_q <= '0;
      warn_q <= 1'b0;
      fault_q <= 1'b0;
    end
    else
    begin
      case (st_q)
        ST_PING:
        begin
          if (sens_trip)
          begin
            st_q <= ST_HOLD;
            hold_ms_q <= RETRY_5MIN_MS; // RULE_07
            fault_q <= 1'b1; // RULE_06
            warn_q <= 1'b0;
          end
          else if (begin_xfer)
            st_q <= ST_XFER;
        end
        ST_XFER:
        begin
          if (sens_trip || loss_trip) // RULE_09
          begin
            st_q <= ST_HOLD;
            hold_ms_q <= RETRY_5MIN_MS;
            fault_q <= 1'b1;
            warn_q <= 1'b0;
          end
          else if (over_current)
          begin
            st_q <= ST_HOLD;
            hold_ms_q <= RETRY_1MIN_MS; // RULE_09
            fault_q <= 1'b1;
            warn_q <= 1'b0;
          end
          else if (loss_warning)
          begin
            st_q <= ST_HOLD;
            hold_ms_q <= WARN_HOLD_MS; // RULE_10
            fault_q <= 1'b0;
            warn_q <= 1'b1;
          end
          else if (ept_valid && ept_code != EPT_RECONF) // RULE_08
          begin
            st_q <= ST_HOLD;
            fault_q <= 1'b0;
            warn_q <= 1'b0;
            if (ept_code == EPT_TEMP)
              hold_ms_q <= RETRY_5MIN_MS;
            else if (ept_code == EPT_DONE || ept_code == 4'h2 || ept_code == 4'h6)
              hold_ms_q <= RETRY_5S_MS;
            else
              hold_ms_q <= '0;
          end
        end
        ST_HOLD:
        begin
          if (rx_removed || hold_ms_q == '0) // RULE_11 RULE_21
          begin
            st_q <= ST_PING;
            hold_ms_q <= '0;
            fault_q <= 1'b0;
            warn_q <= 1'b0;
          end
          else if (tick_q)
            hold_ms_q <= hold_ms_q - 19'h1; // RULE_21
        end
        default:
          st_q <= ST_PING;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Standby pinging and start signals
  // ----------------------------------------------------------------
  logic [18:0] start_ms_q;
  logic [31:0] tone_cnt_q;

  // The ping phase restarts whenever standby is entered, so detection latency is bounded.
  always_ff @(posedge aclk)
  begin
    if (!run || st_q != ST_PING)
    begin
      ping_ms_q <= '0;
      ping_active_q <= 1'b0;
    end
    else
    begin
      ping_active_q <= (ping_ms_q < PING_ACTIVE_MS); // RULE_16
      if (tick_q)
        ping_ms_q <= (ping_ms_q == PING_PERIOD_MS - 19'h1) ? 19'h0 : ping_ms_q + 19'h1;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!run)
    begin
      start_ms_q <= '0;
      start_pulse_q <= 1'b0;
    end
    else if (begin_xfer)
    begin
      start_ms_q <= START_SIG_MS;
      start_pulse_q <= 1'b1; // RULE_13
    end
    else
    begin
      if (tick_q && start_ms_q != '0)
        start_ms_q <= start_ms_q - 19'h1;
      start_pulse_q <= (start_ms_q > 19'h1) || (start_ms_q == 19'h1 && !tick_q);
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!run || !start_pulse_q)
    begin
      tone_cnt_q <= '0;
      tone_q <= 1'b0;
    end
    else if (tone_cnt_q == 32'(CYC_PER_TONE_HALF - 1))
    begin
      tone_cnt_q <= '0;
      tone_q <= !tone_q; // RULE_12
    end
    else
      tone_cnt_q <= tone_cnt_q + 32'h1;
  end

  // ----------------------------------------------------------------
  // Charge level and indicator
  // ----------------------------------------------------------------
  logic full_q;

  always_ff @(posedge aclk)
  begin
    if (!run)
      full_q <= 1'b0;
    else if ((st_q == ST_XFER && ept_valid && ept_code == EPT_DONE) // RULE_18
      || (cs_valid && cs_pct >= CHARGE_FULL_PCT)) // RULE_19
      full_q <= 1'b1;
    else if (cs_valid && cs_pct < CHARGE_RESUME_PCT) // RULE_20
      full_q <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!run)
    begin
      indicator_q <= IND_STANDBY;
      power_enable_q <= 1'b0;
      warn_buzz_q <= 1'b0;
      indicator_scheme_select_q <= SCHEME_RESET;
    end
    else
    begin
      indicator_scheme_select_q <= ctrl_q[CTRL_SCHEME_LSB +: 4];
      power_enable_q <= (st_q == ST_XFER); // RULE_19
      warn_buzz_q <= (st_q == ST_HOLD) && warn_q && (hold_ms_q <= WARN_BUZZ_MS); // RULE_10
      if (st_q == ST_HOLD && fault_q)
        indicator_q <= IND_FAULT; // RULE_06
      else if (st_q == ST_HOLD && warn_q)
        indicator_q <= IND_WARN;
      else if (full_q)
        indicator_q <= IND_FULL; // RULE_18
      else if (st_q == ST_XFER)
        indicator_q <= IND_XFER;
      else
        indicator_q <= IND_STANDBY;
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite register slave
  // ----------------------------------------------------------------
  logic [7:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic aw_have_q;
  logic w_have_q;
  logic do_wr;
  logic [15:0] loss_last_q;
  logic [5:0] ev_q;
  logic [5:0] ev_set;
  logic [5:0] ev_clr;

  assign do_wr = aw_have_q && w_have_q && !s_axi_bvalid;
  assign ev_set = {full_q == 1'b0 && cs_valid && cs_pct >= CHARGE_FULL_PCT,
    st_q == ST_XFER && ept_valid, st_q == ST_XFER && over_current,
    st_q == ST_XFER && loss_warning, sens_trip, st_q == ST_XFER && loss_trip};
  assign ev_clr = (do_wr && aw_addr_q == REG_EVENTS && w_strb_q[0]) ? w_data_q[5:0] : 6'h0;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      aw_addr_q <= '0;
      w_data_q <= '0;
      w_strb_q <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
    end
    else
    begin
      // Ready is registered as the inverse of the next holding state.
      s_axi_awready <= do_wr || (!aw_have_q && !s_axi_awvalid);
      s_axi_wready <= do_wr || (!w_have_q && !s_axi_wvalid);
      if (s_axi_awvalid && !aw_have_q)
      begin
        aw_have_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_have_q)
      begin
        w_have_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (do_wr)
      begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_addr_q == REG_CTRL || aw_addr_q == REG_EVENTS) ?
          RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      ctrl_q <= {20'h0, SCHEME_RESET, BIN_RESET, BIN_RESET};
    else if (do_wr && aw_addr_q == REG_CTRL)
    begin
      for (int i = 0; i < 2; i++)
        if (w_strb_q[i])
          ctrl_q[i*8 +: 8] <= w_data_q[i*8 +: 8];
    end
  end

  // Hardware set wins over a software clear landing in the same cycle.
  always_ff @(posedge aclk)
  begin
    if (!run)
    begin
      ev_q <= '0;
      loss_last_q <= '0;
    end
    else
    begin
      ev_q <= (ev_q & ~ev_clr) | ev_set;
      if (loss_valid)
        loss_last_q <= loss_mw;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= RESP_OKAY;
        case (s_axi_araddr)
          REG_CTRL: s_axi_rdata <= {20'h0, ctrl_q[11:0]};
          REG_STATUS: s_axi_rdata <= {22'h0, indicator_q, full_q, warn_q, fault_q,
            use_legacy_q, sens_s_q, 2'(st_q)};
          REG_RETRY: s_axi_rdata <= {13'h0, hold_ms_q};
          REG_LOSS: s_axi_rdata <= {16'h0, loss_last_q};
          REG_EVENTS: s_axi_rdata <= {26'h0, ev_q};
          default:
          begin
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_SLVERR;
          end
        endcase
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  loss_halt_a: assert property (@(posedge aclk) disable iff (!run) // RULE_01
    st_q == ST_XFER && loss_trip && !sens_trip |=> st_q == ST_HOLD
      && hold_ms_q == RETRY_5MIN_MS && fault_q ##1 !power_enable_q)
    else $error("loss fault did not halt transfer");
  bin_off_a: assert property (@(posedge aclk) disable iff (!run) // RULE_04
    loss_trip |-> sel_bin < BIN_DISABLED && loss_mw > THR_BASE_MW)
    else $error("loss fault raised from a disabled check");
  sensor_trip_a: assert property (@(posedge aclk) disable iff (!run) // RULE_05
    sens_trip && st_q != ST_HOLD |=> st_q == ST_HOLD && hold_ms_q == RETRY_5MIN_MS)
    else $error("sensor shutdown did not start the long wait");
  oc_wait_a: assert property (@(posedge aclk) disable iff (!run) // RULE_09
    st_q == ST_XFER && over_current && !loss_trip && !sens_trip
      |=> hold_ms_q == RETRY_1MIN_MS)
    else $error("over-current wait is wrong");
  warn_buzz_a: assert property (@(posedge aclk) disable iff (!run) // RULE_10
    warn_buzz_q |-> $past(warn_q) && $past(hold_ms_q) <= WARN_BUZZ_MS)
    else $error("warning buzzer outside the final window");
  removal_cut_a: assert property (@(posedge aclk) disable iff (!run) // RULE_11
    st_q == ST_HOLD && rx_removed |=> st_q == ST_PING ##2 indicator_q != IND_FAULT)
    else $error("removal did not end the retry wait");
  start_sig_a: assert property (@(posedge aclk) disable iff (!run) // RULE_13
    begin_xfer |=> start_pulse_q && start_ms_q == START_SIG_MS ##1 start_pulse_q)
    else $error("start pulse did not begin with transfer");
  tone_idle_a: assert property (@(posedge aclk) disable iff (!run) // RULE_12
    !start_pulse_q |=> !tone_q)
    else $error("tone active outside the start window");
  full_set_a: assert property (@(posedge aclk) disable iff (!run) // RULE_19
    cs_valid && cs_pct >= CHARGE_FULL_PCT && st_q == ST_XFER && !sens_trip && !loss_trip
      && !over_current && !loss_warning && !ept_valid
      |=> full_q && st_q == ST_XFER ##1 indicator_q == IND_FULL && power_enable_q)
    else $error("full charge status mishandled");
  full_clr_a: assert property (@(posedge aclk) disable iff (!run) // RULE_20
    cs_valid && cs_pct < CHARGE_RESUME_PCT && !(ept_valid && ept_code == EPT_DONE)
      |=> !full_q)
    else $error("charge indicator not restored below resume level");
  ping_len_a: assert property (@(posedge aclk) disable iff (!run) // RULE_16
    ping_active_q |-> $past(st_q) == ST_PING && $past(ping_ms_q) < PING_ACTIVE_MS)
    else $error("ping active outside its window");
  bresp_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before acceptance");

endmodule : wts_supervisor

// file: testbench/wts_rx_model.sv
// Purpose: Receiver across the link, sending one-cycle packets to the supervisor.
// Assumes: Kinds 0 detect, 1 id, 2 loss, 3 end code, 4 charge status, 5 removal.
// Notes: Payload is inverted after each packet so that stale data never looks fresh.
`timescale 1ns/100ps

module wts_rx_model
(
  input wire logic aclk,
  output logic [5:0] pkt,
  output logic [15:0] data
);
  initial
  begin
    pkt = 6'h00;
    data = 16'h0000;
  end

  task automatic send(input int k, input logic [15:0] v);
    @(posedge aclk);
    pkt[k] <= 1'b1;
    data <= v;
    @(posedge aclk);
    pkt <= 6'h00;
    data <= ~v;
  endtask : send
endmodule : wts_rx_model

// file: testbench/tb_top.sv
// Purpose: Self-checking bench for the fault supervisor.
// Assumes: Millisecond tick of 20 cycles, tone half period of 2 cycles.
// Notes: Retry waits are cut by removal so the run stays short.
`timescale 1ns/100ps

`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin bad_count++; \
  $display("BAD t=%0t got %h exp %h", $time, (a), (b)); end end

module tb_top;
  import wts_pkg::*;
  localparam int MS = 20;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h00000000;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic over_current = 1'b0, warn = 1'b0, sensor = 1'b1;
  logic awready, wready, bvalid, arready, rvalid, power_enable_q, ping_active_q, tone_q;
  logic start_pulse_q, buzz;
  logic [1:0] bresp, rresp, r;
  logic [31:0] rdata, q;
  logic [2:0] indicator_q;
  logic [3:0] scheme_q;
  logic [5:0] pkt;
  logic [15:0] data;
  int bad_count = 0;
  int n_compared = 0;
  int n;

  always #2 aclk = ~aclk;

  wts_rx_model rcv (.aclk(aclk), .pkt(pkt), .data(data));

  wts_supervisor #(.CYC_PER_MS(MS), .CYC_PER_TONE_HALF(2), .POR_LEN(4)) dut (.aclk(aclk),
    .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .sensor_above(sensor), .rx_detected(pkt[0]),
    .rx_removed(pkt[5]), .id_valid(pkt[1]), .id_legacy(data[0]), .loss_valid(pkt[2]),
    .loss_mw(data), .loss_warning(warn), .over_current(over_current), .ept_valid(pkt[3]),
    .ept_code(data[3:0]), .cs_valid(pkt[4]), .cs_pct(data[6:0]),
    .power_enable_q(power_enable_q), .ping_active_q(ping_active_q), .tone_q(tone_q),
    .start_pulse_q(start_pulse_q), .warn_buzz_q(buzz), .indicator_q(indicator_q),
    .indicator_scheme_select_q(scheme_q));

  task automatic close_out();
    $display("Compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : close_out

  // Ready and valid are sampled at the falling edge, so releases land on the next rise.
  task automatic axi(input logic wr, input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, fin;
    fin = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    araddr <= a;
    wdata <= d;
    awvalid <= wr;
    wvalid <= wr;
    bready <= wr;
    arvalid <= !wr;
    rready <= !wr;
    for (n = 0; n < 50 && !fin; n++)
    begin
      @(negedge aclk);
      ta = wr ? awready : arready;
      tw = wready;
      fin = wr ? bvalid : rvalid;
      q = rdata;
      r = wr ? bresp : rresp;
      @(posedge aclk);
      awvalid <= awvalid && !ta;
      arvalid <= arvalid && !ta;
      wvalid <= wvalid && !tw;
      bready <= bready && !fin;
      rready <= rready && !fin;
    end
    if (!fin)
    begin
      bad_count++;
      close_out();
    end
  endtask : axi

  // Select 0 power enable, 1 ping, 2 start pulse; returns at a falling edge.
  task automatic wait_for(input int s, input logic v, output int c);
    for (c = 0; c < 20000; c++)
    begin
      @(negedge aclk);
      if ((s == 0 ? power_enable_q : s == 1 ? ping_active_q : start_pulse_q) === v)
        break;
    end
    if (c == 20000)
    begin
      bad_count++;
      close_out();
    end
  endtask : wait_for

  task automatic start_xfer(input logic legacy);
    wait_for(1, 1'b1, n);
    rcv.send(0, 16'h0000);
    wait_for(0, 1'b1, n);
    rcv.send(1, {15'h0000, legacy});
  endtask : start_xfer

  task automatic trip(input logic [2:0] ind, input int ms);
    wait_for(0, 1'b0, n);
    repeat (2) @(negedge aclk);
    `CHK({indicator_q, buzz}, {ind, 1'b0})
    axi(1'b0, REG_RETRY, 32'h00000000);
    `CHK(q <= ms && q + 2 >= ms, 1'b1)
    rcv.send(5, 16'h0000);
    wait_for(1, 1'b1, n);
    `CHK(n < 20 * MS, 1'b1)
  endtask : trip

  task automatic expect_on(input int k, input logic [15:0] v);
    rcv.send(k, v);
    repeat (4) @(negedge aclk);
    `CHK(power_enable_q, 1'b1)
  endtask : expect_on

  task automatic t_start();
    int k;
    logic t0;
    wait_for(1, 1'b1, n);
    wait_for(1, 1'b0, n);
    `CHK(n >= 209 * MS && n <= 211 * MS, 1'b1)
    `CHK({start_pulse_q, power_enable_q}, 2'b00)
    start_xfer(1'b0);
    wait_for(2, 1'b1, n);
    k = 0;
    @(negedge aclk);
    t0 = tone_q;
    for (int i = 0; i < 8; i++)
    begin
      @(negedge aclk);
      k += (tone_q !== t0);
      t0 = tone_q;
    end
    `CHK(k, 4)
    wait_for(2, 1'b0, n);
    `CHK(n + 10 >= 398 * MS && n + 10 <= 401 * MS, 1'b1)
    @(negedge aclk);
    `CHK({tone_q, power_enable_q}, 2'b01)
    expect_on(2, 16'h0190);
    rcv.send(2, 16'h0191);
    trip(IND_FAULT, 300000);
    $display("Test start and loss done");
  endtask : t_start

  task automatic t_legacy();
    axi(1'b1, REG_CTRL, 32'h000005D0);
    @(negedge aclk);
    `CHK({r, scheme_q}, {RESP_OKAY, 4'h5})
    start_xfer(1'b1);
    expect_on(2, 16'hFFFF);
    rcv.send(1, 16'h0000);
    expect_on(2, 16'h00FA);
    rcv.send(2, 16'h00FB);
    trip(IND_FAULT, 300000);
    $display("Test check selection done");
  endtask : t_legacy

  task automatic t_fault_and_charge();
    start_xfer(1'b0);
    over_current <= 1'b1;
    @(posedge aclk);
    over_current <= 1'b0;
    trip(IND_FAULT, 60000);
    start_xfer(1'b0);
    warn <= 1'b1;
    @(posedge aclk);
    warn <= 1'b0;
    trip(IND_WARN, 12000);
    start_xfer(1'b0);
    sensor <= 1'b0;
    repeat (149 * MS) @(negedge aclk);
    `CHK(power_enable_q, 1'b1)
    trip(IND_FAULT, 300000);
    @(posedge aclk);
    sensor <= 1'b1;
    start_xfer(1'b0);
    expect_on(4, 16'h0064);
    `CHK(indicator_q, IND_FULL)
    expect_on(4, 16'h0059);
    `CHK(indicator_q, IND_XFER)
    expect_on(3, {12'h000, EPT_RECONF});
    rcv.send(3, {12'h000, EPT_DONE});
    trip(IND_FULL, 5000);
    $display("Test over-current and charge done");
  endtask : t_fault_and_charge

  initial
  begin
    repeat (2) @(posedge aclk);
    `CHK({power_enable_q, indicator_q, scheme_q}, {1'b0, IND_STANDBY, SCHEME_RESET})
    aresetn <= 1'b1;
    axi(1'b0, REG_CTRL, 32'h00000000);
    `CHK(q, {20'h00000, SCHEME_RESET, BIN_RESET, BIN_RESET})
    axi(1'b0, 8'h14, 32'h00000000);
    `CHK({r, q}, {RESP_SLVERR, 32'h00000000})
    axi(1'b1, REG_STATUS, 32'hFFFFFFFF);
    `CHK(r, RESP_SLVERR)
    $display("Test registers done");
    t_start();
    t_legacy();
    t_fault_and_charge();
    close_out();
  end
endmodule : tb_top
